/* rtl/phc_defines.svh */
// timing constants and widths for the parallel handshake channel
`ifndef PHC_DEFINES_SVH
`define PHC_DEFINES_SVH
`define PHC_WORD_W      32
`define PHC_CNT_W       16
`define PHC_FIFO_DEPTH  32
`define PHC_FIFO_AW     5
`define PHC_CLK_NS      20
// default acknowledge minimum pulse width and request minimum low time, ns
`define PHC_ACK_MIN_NS  1000
`define PHC_LOW_MIN_NS  1000
`define PHC_ACK_MIN_CYC ((`PHC_ACK_MIN_NS + `PHC_CLK_NS - 1) / `PHC_CLK_NS)
`define PHC_LOW_MIN_CYC ((`PHC_LOW_MIN_NS + `PHC_CLK_NS - 1) / `PHC_CLK_NS)
`endif

/* rtl/phc_pkg.sv */
// types used by the computer end of the parallel handshake channel
package phc_pkg;
  typedef enum logic [1:0] {
    PHC_INTERLOCKED,
    PHC_PIPELINED,
    PHC_INTERLOCKED_PULSED,
    PHC_PIPELINED_PULSED
  } phc_mode_e;
endpackage

/* rtl/phc_if.sv */
// parallel channel wires between computer end and peripheral end
interface phc_if;
  logic        out_word_request;
  logic        out_command_request;
  logic        out_word_ack;
  logic        out_command_ack;
  logic [31:0] out_lines;
  logic        in_word_request;
  logic        in_interrupt_request;
  logic        in_ack;
  logic [31:0] in_lines;
  modport computer (
    input  out_word_request, out_command_request, in_word_request,
           in_interrupt_request, in_lines,
    output out_word_ack, out_command_ack, out_lines, in_ack
  );
  modport peripheral (
    output out_word_request, out_command_request, in_word_request,
           in_interrupt_request, in_lines,
    input  out_word_ack, out_command_ack, out_lines, in_ack
  );
endinterface

/* rtl/phc_fifo.sv */
// flip-flop fifo with valid/ready on both sides
module phc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // full and empty come from the occupancy count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers wrap naturally because depth is a power of two
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop)  rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* rtl/phc_computer.sv */
// computer end: acknowledge sequencing for output and input transfers
`include "phc_defines.svh"
// Functional notes
// - interlocked peripheral waits for full completion
// - ack output with valid word on lines
// - peripheral samples output on ack, drops request
// - interlocked output ack ends after width and release
// - input word sampled, then input ack raised
// - interlocked peripheral may drop request after ack
// - interlocked input ack ends after width and release
// - pipelined peripheral waits low time, reasserts
// - pipelined output ack held exactly width, reuse
// - pipelined input peripheral reasserts after low time
// - pipelined input ack held width, next follows
// - pulsed ack exact width, request ignored
// - pulsed output peripheral honours low time
// - pulsed input ack exact width after sampling
// - pulsed input request respects low time
// - word and interrupt requests never both active
// - forced command ack without any request
module phc_computer (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire phc_pkg::phc_mode_e    cfg_mode,
  input  wire logic [`PHC_CNT_W-1:0] cfg_ack_cycles,
  phc_if.computer                    link,
  input  wire logic [31:0]           tx_data,
  input  wire logic                  tx_is_command,
  input  wire logic                  tx_force,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  output logic [31:0]                rx_data,
  output logic                       rx_is_interrupt,
  output logic                       rx_valid,
  input  wire logic                  rx_ready,
  output logic                       busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_HOLD} phc_st_e;

  phc_pkg::phc_mode_e    mode_r;
  logic [`PHC_CNT_W-1:0] width_r;
  logic [2:0]            owr_s_r, ocr_s_r, iwr_s_r, iir_s_r;
  phc_st_e               ost_r, ost_nxt, ist_r, ist_nxt;
  logic [`PHC_CNT_W-1:0] ocnt_r, icnt_r;
  logic                  ocmd_r, ocmd_nxt, oforce_r, oforce_nxt;
  logic                  oack_w_r, oack_c_r, iack_r;
  logic [31:0]           olines_r;
  logic                  in_int_r;
  logic                  fifo_in_valid, fifo_in_ready;
  logic [32:0]           fifo_out;
  logic                  ow_low_r, oc_low_r, i_low_r;

  // helper: three-stage sync, high only when stages two and three are both high
  function automatic logic sync_ok(input logic [2:0] s);
    return s[1] & s[2];
  endfunction

  // configuration is latched while reset is held
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r  <= cfg_mode;
      width_r <= (cfg_ack_cycles == '0) ? `PHC_CNT_W'(1) : cfg_ack_cycles;
    end
  end

  // requests come from another clock domain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      owr_s_r <= 3'h0;
      ocr_s_r <= 3'h0;
      iwr_s_r <= 3'h0;
      iir_s_r <= 3'h0;
    end else begin
      owr_s_r <= {owr_s_r[1:0], link.out_word_request};
      ocr_s_r <= {ocr_s_r[1:0], link.out_command_request};
      iwr_s_r <= {iwr_s_r[1:0], link.in_word_request};
      iir_s_r <= {iir_s_r[1:0], link.in_interrupt_request};
    end
  end

  wire owr    = sync_ok(owr_s_r);
  wire ocr    = sync_ok(ocr_s_r);
  wire iwr    = sync_ok(iwr_s_r);
  wire iir    = sync_ok(iir_s_r);
  wire pulsed = (mode_r == phc_pkg::PHC_INTERLOCKED_PULSED) ||
                (mode_r == phc_pkg::PHC_PIPELINED_PULSED);
  wire interl = (mode_r == phc_pkg::PHC_INTERLOCKED);
  wire o_req  = ocmd_r ? ocr : owr;
  wire o_done = (ocnt_r >= width_r);
  wire i_done = (icnt_r >= width_r);
  // a request only counts once seen low since its last transfer; the synced
  // copy lags the pin, so a dropped request still looks high for two cycles
  // after a short ack falls and would otherwise start a phantom cycle
  wire ow_new = owr && ow_low_r;
  wire oc_new = ocr && oc_low_r;
  // a forced command may start without any request
  wire o_go   = tx_valid && (tx_force && tx_is_command ||
                             (tx_is_command ? oc_new : ow_new));
  // input taken only when the fifo can hold it, which stalls the peripheral
  wire i_req  = iwr ^ iir;
  wire i_go   = i_req && i_low_r && fifo_in_ready;

  assign tx_ready      = (ost_r == ST_IDLE) && o_go;
  assign fifo_in_valid = (ist_r == ST_IDLE) && i_go;

  // freshness flags: a low request re-arms, starting a transfer disarms
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ow_low_r <= 1'b0;
      oc_low_r <= 1'b0;
      i_low_r  <= 1'b0;
    end else begin
      ow_low_r <= !owr || (ow_low_r && !(tx_ready && !tx_is_command));
      oc_low_r <= !ocr || (oc_low_r && !(tx_ready && tx_is_command && !tx_force));
      i_low_r  <= !(iwr || iir) || (i_low_r && !fifo_in_valid);
    end
  end

  // output machine: ack rises, held per discipline, falls to complete
  always_comb begin
    ost_nxt    = ost_r;
    ocmd_nxt   = ocmd_r;
    oforce_nxt = oforce_r;
    case (ost_r)
      ST_IDLE: begin
        if (o_go) begin
          ost_nxt    = ST_ACK;
          ocmd_nxt   = tx_is_command;
          oforce_nxt = tx_force && tx_is_command;
        end
      end
      ST_ACK: begin
        // pulsed, pipelined and forced transfers release after the width
        if (o_done && (pulsed || !interl || oforce_r)) ost_nxt = ST_IDLE;
        else if (o_done) ost_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (!o_req) ost_nxt = ST_IDLE;
      end
      default: ost_nxt = ST_IDLE;
    endcase
  end

  // input machine mirrors the output one
  always_comb begin
    ist_nxt = ist_r;
    case (ist_r)
      ST_IDLE: if (i_go) ist_nxt = ST_ACK;
      ST_ACK: begin
        if (i_done && (pulsed || !interl)) ist_nxt = ST_IDLE;
        else if (i_done) ist_nxt = ST_HOLD;
      end
      ST_HOLD: if (!i_req) ist_nxt = ST_IDLE;
      default: ist_nxt = ST_IDLE;
    endcase
  end

  // state, counters and registered pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ost_r    <= ST_IDLE;
      ist_r    <= ST_IDLE;
      ocnt_r   <= '0;
      icnt_r   <= '0;
      ocmd_r   <= 1'b0;
      oforce_r <= 1'b0;
      oack_w_r <= 1'b0;
      oack_c_r <= 1'b0;
      iack_r   <= 1'b0;
      olines_r <= 32'h0;
    end else begin
      ost_r    <= ost_nxt;
      ist_r    <= ist_nxt;
      ocmd_r   <= ocmd_nxt;
      oforce_r <= oforce_nxt;
      ocnt_r   <= (ost_nxt == ST_ACK) ? ocnt_r + 1'b1 : '0;
      icnt_r   <= (ist_nxt == ST_ACK) ? icnt_r + 1'b1 : '0;
      oack_w_r <= (ost_nxt != ST_IDLE) && !ocmd_nxt;
      oack_c_r <= (ost_nxt != ST_IDLE) && ocmd_nxt;
      iack_r   <= (ist_nxt != ST_IDLE);
      if (tx_ready) olines_r <= tx_data;
    end
  end

  assign link.out_word_ack    = oack_w_r;
  assign link.out_command_ack = oack_c_r;
  assign link.out_lines       = olines_r;
  assign link.in_ack          = iack_r;

  // received words wait in a fifo for the user side
  phc_fifo #(.WIDTH(33), .DEPTH(`PHC_FIFO_DEPTH), .AW(`PHC_FIFO_AW)) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   ({iir, link.in_lines}),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );
  assign rx_data         = fifo_out[31:0];
  assign rx_is_interrupt = fifo_out[32];

  always_ff @(posedge clk) begin
    if (!resetn) in_int_r <= 1'b0;
    else         in_int_r <= (ost_nxt != ST_IDLE) || (ist_nxt != ST_IDLE);
  end
  assign busy = in_int_r;
endmodule

/* rtl/phc_peripheral.sv */
// peripheral end: raises requests, samples output, sends input words
`include "phc_defines.svh"
module phc_peripheral (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  cfg_pipelined,
  input  wire logic [`PHC_CNT_W-1:0] cfg_low_cycles,
  phc_if.peripheral                  link,
  input  wire logic                  want_word,
  input  wire logic                  want_command,
  output logic [31:0]                got_data,
  output logic                       got_is_command,
  output logic                       got_valid,
  input  wire logic [31:0]           send_data,
  input  wire logic                  send_is_interrupt,
  input  wire logic                  send_valid,
  output logic                       send_ready
);
  logic                  pipe_r;
  logic [`PHC_CNT_W-1:0] low_r;
  logic [2:0]            ow_s_r, oc_s_r, ia_s_r;
  logic                  owr_r, ocr_r, iwr_r, iir_r;
  logic [`PHC_CNT_W-1:0] olow_r, ilow_r;
  logic                  oseen_r, iseen_r;
  logic [31:0]           ilines_r, got_r;
  logic                  gotc_r, gotv_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pipe_r <= cfg_pipelined;
      low_r  <= (cfg_low_cycles == '0) ? `PHC_CNT_W'(1) : cfg_low_cycles;
    end
  end

  wire oaw = ow_s_r[1] & ow_s_r[2];
  wire oac = oc_s_r[1] & oc_s_r[2];
  wire ia  = ia_s_r[1] & ia_s_r[2];
  wire oa  = oaw | oac;
  // both wait for the low time and for the sampled ack to have been seen low; interlocked also waits for ack release
  wire o_free = (olow_r >= low_r) && (pipe_r || !oa) && !oseen_r;
  wire i_free = (ilow_r >= low_r) && (pipe_r || !ia) && !iseen_r;
  assign send_ready = i_free && !iwr_r && !iir_r;

  // acks are from another domain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ow_s_r <= 3'h0;
      oc_s_r <= 3'h0;
      ia_s_r <= 3'h0;
    end else begin
      ow_s_r <= {ow_s_r[1:0], link.out_word_ack};
      oc_s_r <= {oc_s_r[1:0], link.out_command_ack};
      ia_s_r <= {ia_s_r[1:0], link.in_ack};
    end
  end

  // output side: sample on ack, drop, time the low period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      owr_r   <= 1'b0;
      ocr_r   <= 1'b0;
      olow_r  <= '0;
      oseen_r <= 1'b0;
      got_r   <= 32'h0;
      gotc_r  <= 1'b0;
      gotv_r  <= 1'b0;
    end else begin
      gotv_r <= 1'b0;
      if (oa && !oseen_r) begin
        got_r   <= link.out_lines;
        gotc_r  <= oac;
        gotv_r  <= 1'b1;
        oseen_r <= 1'b1;
        owr_r   <= 1'b0;
        ocr_r   <= 1'b0;
      end else if (!oa) begin
        oseen_r <= 1'b0;
      end
      if (owr_r || ocr_r || (oa && !oseen_r)) olow_r <= '0;
      else if (olow_r < low_r) olow_r <= olow_r + 1'b1;
      if (o_free && !owr_r && !ocr_r) begin
        owr_r <= want_word;
        ocr_r <= want_command && !want_word;
      end
    end
  end

  // input side: one request at a time, drop after ack seen
  always_ff @(posedge clk) begin
    if (!resetn) begin
      iwr_r    <= 1'b0;
      iir_r    <= 1'b0;
      ilow_r   <= '0;
      iseen_r  <= 1'b0;
      ilines_r <= 32'h0;
    end else begin
      if (ia && (iwr_r || iir_r)) begin
        iwr_r   <= 1'b0;
        iir_r   <= 1'b0;
        iseen_r <= 1'b1;
      end else if (!ia) begin
        iseen_r <= 1'b0;
      end
      if (iwr_r || iir_r) ilow_r <= '0;
      else if (ilow_r < low_r) ilow_r <= ilow_r + 1'b1;
      if (send_valid && send_ready) begin
        ilines_r <= send_data;
        iwr_r    <= !send_is_interrupt;
        iir_r    <= send_is_interrupt;
      end
    end
  end

  assign link.out_word_request     = owr_r;
  assign link.out_command_request  = ocr_r;
  assign link.in_word_request      = iwr_r;
  assign link.in_interrupt_request = iir_r;
  assign link.in_lines             = ilines_r;
  assign got_data                  = got_r;
  assign got_is_command            = gotc_r;
  assign got_valid                 = gotv_r;
endmodule

/* test/phc_chk.sv */
// concurrent checks on the wires between computer end and peripheral end
module phc_chk #(
  parameter int ACK = 4
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        out_word_request,
  input wire logic        out_command_request,
  input wire logic        out_word_ack,
  input wire logic        out_command_ack,
  input wire logic [31:0] out_lines,
  input wire logic        in_word_request,
  input wire logic        in_interrupt_request,
  input wire logic        in_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wcnt_r;
  logic [15:0] ccnt_r;
  logic [15:0] icnt_r;
  logic        in_req;
  assign in_req = in_word_request || in_interrupt_request;
  // high-time of each ack; cleared while low so a falling edge sees the whole pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wcnt_r <= 16'h0000;
      ccnt_r <= 16'h0000;
      icnt_r <= 16'h0000;
    end else begin
      wcnt_r <= out_word_ack ? wcnt_r + 16'h0001 : 16'h0000;
      ccnt_r <= out_command_ack ? ccnt_r + 16'h0001 : 16'h0000;
      icnt_r <= in_ack ? icnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_word_ack_width: assert property ($fell(out_word_ack) |-> wcnt_r >= 16'(ACK))
    else $error("word ack shorter than minimum");
  a_cmd_ack_width: assert property ($fell(out_command_ack) |-> ccnt_r >= 16'(ACK))
    else $error("command ack shorter than minimum");
  a_in_ack_width: assert property ($fell(in_ack) |-> icnt_r >= 16'(ACK))
    else $error("input ack shorter than minimum");
  a_lines_held: assert property ((out_word_ack || out_command_ack) &&
    $past(out_word_ack || out_command_ack) |-> $stable(out_lines))
    else $error("output lines moved under ack");
  a_acks_apart: assert property (!(out_word_ack && out_command_ack))
    else $error("both output acks active");
  a_word_ack_req: assert property ($rose(out_word_ack) |-> $past(out_word_request))
    else $error("word ack without request");
  a_in_ack_sync: assert property ($rose(in_ack) |-> $past(in_req, 3))
    else $error("input ack too soon after request");
  a_ack_release: assert property ($rose(out_word_ack) |-> ##[1:200] !out_word_ack)
    else $error("word ack never released");
endmodule

/* test/parallel_handshake_channel_tb_top.sv */
// end-to-end bench: computer end facing peripheral end across the channel
module parallel_handshake_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk;
  logic               resetn;
  phc_pkg::phc_mode_e cfg_mode;
  logic               cfg_pipelined;
  logic [31:0]        tx_data;
  logic               tx_is_command;
  logic               tx_force;
  logic               tx_valid;
  logic               tx_ready;
  logic [31:0]        rx_data;
  logic               rx_is_interrupt;
  logic               rx_valid;
  logic               rx_ready;
  logic               busy;
  logic               want_word;
  logic               want_command;
  logic [31:0]        got_data;
  logic               got_is_command;
  logic               got_valid;
  logic [31:0]        send_data;
  logic               send_is_interrupt;
  logic               send_valid;
  logic               send_ready;
  int                 mismatches;
  int                 compares;
  int                 m;
  int                 n;
  int                 acc;
  int                 idle;
  phc_if link ();
  // short widths keep every mode quick; both ends get the same figure
  phc_computer phc_computer_i (.clk(clk), .resetn(resetn), .cfg_mode(cfg_mode),
    .cfg_ack_cycles(16'h0004), .link(link), .tx_data(tx_data), .tx_is_command(tx_is_command),
    .tx_force(tx_force), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_is_interrupt(rx_is_interrupt), .rx_valid(rx_valid), .rx_ready(rx_ready), .busy(busy));
  phc_peripheral phc_peripheral_i (.clk(clk), .resetn(resetn), .cfg_pipelined(cfg_pipelined),
    .cfg_low_cycles(16'h0004), .link(link), .want_word(want_word),
    .want_command(want_command), .got_data(got_data), .got_is_command(got_is_command),
    .got_valid(got_valid), .send_data(send_data), .send_is_interrupt(send_is_interrupt),
    .send_valid(send_valid), .send_ready(send_ready));
  phc_chk #(.ACK(4)) phc_chk_i (.clk(clk), .resetn(resetn),
    .out_word_request(link.out_word_request), .out_command_request(link.out_command_request),
    .out_word_ack(link.out_word_ack), .out_command_ack(link.out_command_ack),
    .out_lines(link.out_lines), .in_word_request(link.in_word_request),
    .in_interrupt_request(link.in_interrupt_request), .in_ack(link.in_ack));
  // 50 MHz
  always #10 clk = ~clk;
  task automatic results();
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // bounded wait on one handshake; a hang ends the run as a failure
  task automatic wait_on(input int w);
    logic s;
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      s = (w == 0) ? tx_ready : (w == 1) ? got_valid : (w == 2) ? send_ready : rx_valid;
      if (s === 1'b1) return;
    end
    mismatches++;
    $display("BAD %0t timeout on handshake %0d", $time, w);
    results();
  endtask
  task automatic rst(input phc_pkg::phc_mode_e md);
    @(posedge clk);
    resetn <= 1'b0;
    cfg_mode <= md;
    cfg_pipelined <= (md == phc_pkg::PHC_PIPELINED) || (md == phc_pkg::PHC_PIPELINED_PULSED);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  // one output word or command; forced commands leave the peripheral request low
  task automatic xfer_out(input logic [31:0] d, input logic cmd, input logic frc);
    @(posedge clk);
    tx_data <= d;
    tx_is_command <= cmd;
    tx_force <= frc;
    tx_valid <= 1'b1;
    want_word <= !cmd;
    want_command <= cmd && !frc;
    wait_on(0);
    tx_valid <= 1'b0;
    @(posedge clk);
    chk({32'h00000000, busy}, 33'h000000001);
    wait_on(1);
    want_word <= 1'b0;
    want_command <= 1'b0;
    chk({got_is_command, got_data}, {cmd, d});
  endtask
  task automatic xfer_in(input logic [31:0] d, input logic intr);
    @(posedge clk);
    send_data <= d;
    send_is_interrupt <= intr;
    send_valid <= 1'b1;
    wait_on(2);
    send_valid <= 1'b0;
    wait_on(3);
    chk({rx_is_interrupt, rx_data}, {intr, d});
  endtask
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    cfg_mode = phc_pkg::PHC_INTERLOCKED;
    cfg_pipelined = 1'b0;
    tx_data = 32'h00000000;
    tx_is_command = 1'b0;
    tx_force = 1'b0;
    tx_valid = 1'b0;
    rx_ready = 1'b1;
    want_word = 1'b0;
    want_command = 1'b0;
    send_data = 32'h00000000;
    send_is_interrupt = 1'b0;
    send_valid = 1'b0;
    mismatches = 0;
    compares = 0;
    // every timing discipline, back-to-back transfers of each kind
    for (m = 0; m < 4; m++) begin
      rst(phc_pkg::phc_mode_e'(m));
      xfer_out(32'hFFFFFFFF, 1'b0, 1'b0);
      xfer_out(32'h5A5A0000 + m, 1'b0, 1'b0);
      xfer_out(32'h00000C00 + m, 1'b1, 1'b0);
      xfer_out(32'h00000F00 + m, 1'b1, 1'b1);
      xfer_in(32'h80000001 + m, 1'b0);
      xfer_in(32'h00001E00 + m, 1'b1);
      xfer_in(32'h7FFFFFFF, 1'b0);
    end
    // stall the receiver until input is refused, then drain in order
    rst(phc_pkg::PHC_INTERLOCKED);
    rx_ready <= 1'b0;
    send_data <= 32'hA0000000;
    send_is_interrupt <= 1'b0;
    send_valid <= 1'b1;
    acc = 0;
    idle = 0;
    for (n = 0; n < 4000 && idle < 200; n++) begin
      @(posedge clk);
      if (send_ready === 1'b1) begin
        acc++;
        idle = 0;
        send_data <= 32'hA0000000 + acc;
      end else begin
        idle++;
      end
    end
    send_valid <= 1'b0;
    chk({32'h00000000, acc >= 32}, 33'h000000001);
    chk({32'h00000000, idle >= 200}, 33'h000000001);
    rx_ready <= 1'b1;
    for (n = 0; n < acc; n++) begin
      wait_on(3);
      chk({rx_is_interrupt, rx_data}, {1'b0, 32'hA0000000 + n});
    end
    repeat (40) @(posedge clk);
    chk({32'h00000000, rx_valid}, 33'h000000000);
    chk({32'h00000000, busy}, 33'h000000000);
    results();
  end
endmodule
